// >>> hdl/iopx_top.sv
// three general purpose ports with two external interrupt groups,
// clock-out and slow clock prescaler
// assumes pins are sampled in the system clock domain; external pad
// logic resolves o/oe/pu into the wire level
`timescale 1ns/100ps
module iopx_top (
   input wire logic clk_sys_i,            // system (oscillator) clock
   input wire logic rstn_i,               // async reset, active low
   input wire logic [3:0] addr_i,         // register address
   input wire logic [7:0] wdata_i,        // write data
   input wire logic wr_i,                 // write strobe
   input wire logic rd_i,                 // read strobe
   output logic [7:0] rdata_o,            // read data, cycle after rd_i
   input wire logic [1:0] cpu_irq_mask_i, // cpu condition code mask bits
   input wire logic [1:0] vec_fetch_i,    // vector fetch per group
   input wire logic [7:0] pa_i,           // port a pin levels
   input wire logic [7:0] pb_i,           // port b pin levels
   input wire logic [5:0] pc_i,           // port c pin levels
   input wire logic [7:0] pa_alt_en_i,    // peripheral output enables port a
   input wire logic [7:0] pa_alt_o_i,     // peripheral output levels port a
   input wire logic [7:0] pb_alt_en_i,    // peripheral output enables port b
   input wire logic [7:0] pb_alt_o_i,     // peripheral output levels port b
   input wire logic [5:0] pc_alt_en_i,    // peripheral output enables port c
   input wire logic [5:0] pc_alt_o_i,     // peripheral output levels port c
   input wire logic [1:0] pc_in_group_i,  // port c joins group 0 / 1
   output iopx_pkg::iopx_pins_t pa_o,     // port a pad controls
   output iopx_pkg::iopx_pins_t pb_o,     // port b pad controls
   output iopx_pkg::iopx_pins_t pc_o,     // port c pad controls (bits 5:0)
   output iopx_pkg::iopx_spi_t spi_ctl_o, // spi pin controls
   output logic cpu_clk_en_o,             // cpu clock enable pulse
   output logic [1:0] ext_irq_o           // requests group0, group1
);
   // ------------------------------------------------------------
   // functions
   // ------------------------------------------------------------
   // pad control for one port; tod marks true open drain pins
   function automatic iopx_pkg::iopx_pins_t pad_ctl(input logic [7:0] dat,
         input logic [7:0] dir, input logic [7:0] opt, input logic [7:0] tod,
         input logic [7:0] alt_en, input logic [7:0] alt_o);
      iopx_pkg::iopx_pins_t p;
      logic [7:0] lvl;
      logic [7:0] pp;
      lvl = (alt_en & alt_o) | (~alt_en & dat);
      // true open drain never drives high, not even for a peripheral
      pp = (opt | alt_en) & ~tod;
      // open drain only pulls low; push-pull drives both levels
      p.o = lvl;
      p.oe = (dir | alt_en) & (pp | ~lvl);
      p.pu = ~dir & ~alt_en & opt & ~tod;
      return p;
   endfunction : pad_ctl

   function automatic logic [7:0] rd_mux(input logic [7:0] dat,
         input logic [7:0] dir, input logic [7:0] pin);
      return (dir & dat) | (~dir & pin);
   endfunction : rd_mux

   // group request; inputs with option set are interrupt capable
   function automatic logic grp_evt(input logic [1:0] sens,
         input logic [7:0] en, input logic [7:0] cur, input logic [7:0] prv);
      logic c;
      logic p;
      // wired combination: any enabled low pin pulls the line low
      c = &(cur | ~en);
      p = &(prv | ~en);
      case (sens)
         iopx_pkg::IOPX_SENS_FALL_LOW: grp_evt = ~c;
         iopx_pkg::IOPX_SENS_RISE: grp_evt = c & ~p;
         iopx_pkg::IOPX_SENS_FALL: grp_evt = ~c & p;
         iopx_pkg::IOPX_SENS_BOTH: grp_evt = c ^ p;
         default: grp_evt = 1'b0;
      endcase
   endfunction : grp_evt

   // ------------------------------------------------------------
   // registers
   // ------------------------------------------------------------
   logic [7:0] pa_dat_r, pa_dir_r, pa_opt_r;
   logic [7:0] pb_dat_r, pb_dir_r, pb_opt_r;
   logic [7:0] pc_dat_r, pc_dir_r, pc_opt_r;
   logic [7:0] misc1_r, misc2_r;
   logic [7:0] pa_s1_r, pa_s2_r, pa_s3_r;
   logic [7:0] pb_s1_r, pb_s2_r, pb_s3_r;
   logic [5:0] pc_s1_r, pc_s2_r, pc_s3_r;
   logic [1:0] irq_r;
   logic [3:0] div_cnt_r;
   logic cpu_clk_en_r;
   logic clk_out_r;

   wire wr_pa_dat = wr_i && addr_i == iopx_pkg::IOPX_PA_DATA;
   wire wr_pa_dir = wr_i && addr_i == iopx_pkg::IOPX_PA_DIR;
   wire wr_pa_opt = wr_i && addr_i == iopx_pkg::IOPX_PA_OPT;
   wire wr_pb_dat = wr_i && addr_i == iopx_pkg::IOPX_PB_DATA;
   wire wr_pb_dir = wr_i && addr_i == iopx_pkg::IOPX_PB_DIR;
   wire wr_pb_opt = wr_i && addr_i == iopx_pkg::IOPX_PB_OPT;
   wire wr_pc_dat = wr_i && addr_i == iopx_pkg::IOPX_PC_DATA;
   wire wr_pc_dir = wr_i && addr_i == iopx_pkg::IOPX_PC_DIR;
   wire wr_pc_opt = wr_i && addr_i == iopx_pkg::IOPX_PC_OPT;
   wire wr_misc1 = wr_i && addr_i == iopx_pkg::IOPX_MISC1;
   wire wr_misc2 = wr_i && addr_i == iopx_pkg::IOPX_MISC2;
   // sensitivity fields are locked unless the cpu has masked interrupts
   wire sens_ok = &cpu_irq_mask_i;

   wire [1:0] is1_cur = misc1_r[iopx_pkg::IOPX_IS1_HI:iopx_pkg::IOPX_IS1_LO];
   wire [1:0] is0_cur = misc1_r[iopx_pkg::IOPX_IS0_HI:iopx_pkg::IOPX_IS0_LO];
   wire [1:0] is1_wr = wdata_i[iopx_pkg::IOPX_IS1_HI:iopx_pkg::IOPX_IS1_LO];
   wire [1:0] is0_wr = wdata_i[iopx_pkg::IOPX_IS0_HI:iopx_pkg::IOPX_IS0_LO];
   wire [1:0] is1_nxt = sens_ok ? is1_wr : is1_cur;
   wire [1:0] is0_nxt = sens_ok ? is0_wr : is0_cur;
   wire [7:0] misc1_nxt = {is1_nxt, wdata_i[iopx_pkg::IOPX_MCO], is0_nxt,
                           wdata_i[iopx_pkg::IOPX_CP_HI:iopx_pkg::IOPX_SMS]};
   wire [1:0] sens_chg = {wr_misc1 && is1_nxt != is1_cur,
                          wr_misc1 && is0_nxt != is0_cur};

   always_ff @(posedge clk_sys_i or negedge rstn_i) begin
      if (!rstn_i) begin
         pa_dat_r <= iopx_pkg::IOPX_RST;
         pa_dir_r <= iopx_pkg::IOPX_RST;
         pa_opt_r <= iopx_pkg::IOPX_RST;
         pb_dat_r <= iopx_pkg::IOPX_RST;
         pb_dir_r <= iopx_pkg::IOPX_RST;
         pb_opt_r <= iopx_pkg::IOPX_RST;
         pc_dat_r <= iopx_pkg::IOPX_RST;
         pc_dir_r <= iopx_pkg::IOPX_RST;
         pc_opt_r <= iopx_pkg::IOPX_RST;
         misc1_r <= iopx_pkg::IOPX_RST;
         misc2_r <= iopx_pkg::IOPX_RST;
      end else begin
         if (wr_pa_dat) pa_dat_r <= wdata_i;
         if (wr_pa_dir) pa_dir_r <= wdata_i;
         if (wr_pa_opt) pa_opt_r <= wdata_i;
         if (wr_pb_dat) pb_dat_r <= wdata_i;
         if (wr_pb_dir) pb_dir_r <= wdata_i;
         if (wr_pb_opt) pb_opt_r <= wdata_i;
         if (wr_pc_dat) pc_dat_r <= wdata_i & iopx_pkg::IOPX_PC_MASK;
         if (wr_pc_dir) pc_dir_r <= wdata_i & iopx_pkg::IOPX_PC_MASK;
         if (wr_pc_opt) pc_opt_r <= wdata_i & iopx_pkg::IOPX_PC_MASK;
         if (wr_misc1) misc1_r <= misc1_nxt;
         if (wr_misc2) misc2_r <= wdata_i & iopx_pkg::IOPX_MISC2_MASK;
      end
   end

   // ------------------------------------------------------------
   // pin synchronisers
   // ------------------------------------------------------------
   // s1 feeds only s2; s2 is the sampled level, s3 the previous one
   always_ff @(posedge clk_sys_i or negedge rstn_i) begin
      if (!rstn_i) begin
         pa_s1_r <= 8'hFF;
         pa_s2_r <= 8'hFF;
         pa_s3_r <= 8'hFF;
         pb_s1_r <= 8'hFF;
         pb_s2_r <= 8'hFF;
         pb_s3_r <= 8'hFF;
         pc_s1_r <= 6'h3F;
         pc_s2_r <= 6'h3F;
         pc_s3_r <= 6'h3F;
      end else begin
         pa_s1_r <= pa_i;
         pa_s2_r <= pa_s1_r;
         pa_s3_r <= pa_s2_r;
         pb_s1_r <= pb_i;
         pb_s2_r <= pb_s1_r;
         pb_s3_r <= pb_s2_r;
         pc_s1_r <= pc_i;
         pc_s2_r <= pc_s1_r;
         pc_s3_r <= pc_s2_r;
      end
   end

   // ------------------------------------------------------------
   // external interrupts
   // ------------------------------------------------------------
   wire [7:0] pc_s2_w = {2'h0, pc_s2_r};
   wire [7:0] pc_s3_w = {2'h0, pc_s3_r};
   wire [7:0] pa_ien = ~pa_dir_r & pa_opt_r;
   wire [7:0] pb_ien = ~pb_dir_r & pb_opt_r;
   wire [7:0] pc_ien = ~pc_dir_r & pc_opt_r & iopx_pkg::IOPX_PC_MASK;
   wire [7:0] g0_en_c = pc_in_group_i[0] ? pc_ien : 8'h00;
   wire [7:0] g1_en_c = pc_in_group_i[1] ? pc_ien : 8'h00;
   wire [15:0] g0_en = {g0_en_c, pa_ien};
   wire [15:0] g1_en = {g1_en_c, pb_ien};
   wire g0_evt = grp_evt(is0_cur, g0_en[7:0], pa_s2_r, pa_s3_r) |
                 grp_evt(is0_cur, g0_en[15:8], pc_s2_w, pc_s3_w);
   wire g1_evt = grp_evt(is1_cur, g1_en[7:0], pb_s2_r, pb_s3_r) |
                 grp_evt(is1_cur, g1_en[15:8], pc_s2_w, pc_s3_w);
   wire [1:0] evt = {g1_evt, g0_evt};
   // an event in the fetch cycle survives: set wins over clear
   wire [1:0] irq_nxt = evt | (irq_r & ~vec_fetch_i & ~sens_chg);

   always_ff @(posedge clk_sys_i or negedge rstn_i) begin
      if (!rstn_i) irq_r <= 2'h0;
      else irq_r <= irq_nxt;
   end

   // ------------------------------------------------------------
   // cpu clock prescaler and clock-out
   // ------------------------------------------------------------
   wire [1:0] cp_sel = misc1_r[iopx_pkg::IOPX_CP_HI:iopx_pkg::IOPX_CP_LO];
   logic [3:0] div_lim;
   always_comb begin
      case (cp_sel)
         iopx_pkg::IOPX_DIV2: div_lim = iopx_pkg::IOPX_LIM2;
         iopx_pkg::IOPX_DIV4: div_lim = iopx_pkg::IOPX_LIM4;
         iopx_pkg::IOPX_DIV8: div_lim = iopx_pkg::IOPX_LIM8;
         iopx_pkg::IOPX_DIV16: div_lim = iopx_pkg::IOPX_LIM16;
         default: div_lim = iopx_pkg::IOPX_LIM2;
      endcase
   end
   wire slow = misc1_r[iopx_pkg::IOPX_SMS];
   // the divider toggles the clock-out half-period every limit+1 cycles
   wire div_wrap = div_cnt_r >= div_lim;
   wire [3:0] div_cnt_nxt = (!slow || div_wrap) ? 4'h0 : div_cnt_r + 4'h1;
   wire clk_out_nxt = slow ? (div_wrap ? ~clk_out_r : clk_out_r) : ~clk_out_r;
   // enable on rising half of the divided clock; every cycle in normal mode
   wire cpu_en_nxt = !slow || (div_wrap && !clk_out_r);

   always_ff @(posedge clk_sys_i or negedge rstn_i) begin
      if (!rstn_i) begin
         div_cnt_r <= 4'h0;
         clk_out_r <= 1'b0;
         cpu_clk_en_r <= 1'b0;
      end else begin
         div_cnt_r <= div_cnt_nxt;
         clk_out_r <= clk_out_nxt;
         cpu_clk_en_r <= cpu_en_nxt;
      end
   end

   // ------------------------------------------------------------
   // pad controls and read port
   // ------------------------------------------------------------
   wire cpu_clock_out_enable = misc1_r[iopx_pkg::IOPX_MCO];
   wire [7:0] pc_alt_en_w = {2'h0, pc_alt_en_i} |
                            (cpu_clock_out_enable ? 8'h04 : 8'h00);
   wire [7:0] pc_alt_o_w = {2'h0, pc_alt_o_i[5:3], clk_out_r, pc_alt_o_i[1:0]};
   // pins without an option bit would pass 8'h00 here; all have one
   iopx_pkg::iopx_pins_t pa_nxt, pb_nxt, pc_nxt;
   assign pa_nxt = pad_ctl(pa_dat_r, pa_dir_r, pa_opt_r, iopx_pkg::IOPX_PA_TOD,
                           pa_alt_en_i, pa_alt_o_i);
   assign pb_nxt = pad_ctl(pb_dat_r, pb_dir_r, pb_opt_r, 8'h00,
                           pb_alt_en_i, pb_alt_o_i);
   assign pc_nxt = pad_ctl(pc_dat_r, pc_dir_r, pc_opt_r, 8'h00,
                           pc_alt_en_w, pc_alt_o_w);
   iopx_pkg::iopx_spi_t spi_nxt;
   assign spi_nxt.ss_int = misc2_r[iopx_pkg::IOPX_SSM];
   assign spi_nxt.ss_lvl = misc2_r[iopx_pkg::IOPX_SSI];
   assign spi_nxt.mosi_dis = misc2_r[iopx_pkg::IOPX_MOD];
   assign spi_nxt.miso_dis = misc2_r[iopx_pkg::IOPX_SOD];

   logic [7:0] rd_nxt;
   always_comb begin
      case (addr_i)
         iopx_pkg::IOPX_PA_DATA: rd_nxt = rd_mux(pa_dat_r, pa_dir_r, pa_s2_r);
         iopx_pkg::IOPX_PA_DIR: rd_nxt = pa_dir_r;
         iopx_pkg::IOPX_PA_OPT: rd_nxt = pa_opt_r;
         iopx_pkg::IOPX_PB_DATA: rd_nxt = rd_mux(pb_dat_r, pb_dir_r, pb_s2_r);
         iopx_pkg::IOPX_PB_DIR: rd_nxt = pb_dir_r;
         iopx_pkg::IOPX_PB_OPT: rd_nxt = pb_opt_r;
         iopx_pkg::IOPX_PC_DATA: rd_nxt = rd_mux(pc_dat_r, pc_dir_r, pc_s2_w);
         iopx_pkg::IOPX_PC_DIR: rd_nxt = pc_dir_r;
         iopx_pkg::IOPX_PC_OPT: rd_nxt = pc_opt_r;
         iopx_pkg::IOPX_MISC1: rd_nxt = misc1_r;
         iopx_pkg::IOPX_MISC2: rd_nxt = misc2_r;
         default: rd_nxt = 8'h00;
      endcase
      if (!rd_i) rd_nxt = 8'h00;
   end

   always_ff @(posedge clk_sys_i or negedge rstn_i) begin
      if (!rstn_i) begin
         rdata_o <= 8'h00;
         pa_o <= '0;
         pb_o <= '0;
         pc_o <= '0;
         spi_ctl_o <= '0;
         cpu_clk_en_o <= 1'b0;
         ext_irq_o <= 2'h0;
      end else begin
         rdata_o <= rd_nxt;
         pa_o <= pa_nxt;
         pb_o <= pb_nxt;
         pc_o <= pc_nxt;
         spi_ctl_o <= spi_nxt;
         cpu_clk_en_o <= cpu_clk_en_r;
         ext_irq_o <= irq_r;
      end
   end
endmodule : iopx_top

// >>> hdl/iopx_pkg.sv
// constants, field layouts and carrier types of the three-port i/o block
// assumes a byte-wide register port and a single system clock
package iopx_pkg;
   // ------------------------------------------------------------
   // register offsets
   // ------------------------------------------------------------
   localparam logic [3:0] IOPX_PC_DATA = 4'h0;
   localparam logic [3:0] IOPX_PC_DIR = 4'h1;
   localparam logic [3:0] IOPX_PC_OPT = 4'h2;
   localparam logic [3:0] IOPX_PB_DATA = 4'h4;
   localparam logic [3:0] IOPX_PB_DIR = 4'h5;
   localparam logic [3:0] IOPX_PB_OPT = 4'h6;
   localparam logic [3:0] IOPX_PA_DATA = 4'h8;
   localparam logic [3:0] IOPX_PA_DIR = 4'h9;
   localparam logic [3:0] IOPX_PA_OPT = 4'hA;
   localparam logic [3:0] IOPX_MISC1 = 4'hC;
   localparam logic [3:0] IOPX_MISC2 = 4'hD;
   // ------------------------------------------------------------
   // field layout and reset values
   // ------------------------------------------------------------
   localparam logic [7:0] IOPX_RST = 8'h00;
   localparam int IOPX_IS1_HI = 7;
   localparam int IOPX_IS1_LO = 6;
   localparam int IOPX_MCO = 5;
   localparam int IOPX_IS0_HI = 4;
   localparam int IOPX_IS0_LO = 3;
   localparam int IOPX_CP_HI = 2;
   localparam int IOPX_CP_LO = 1;
   localparam int IOPX_SMS = 0;
   localparam int IOPX_MOD = 3;
   localparam int IOPX_SOD = 2;
   localparam int IOPX_SSM = 1;
   localparam int IOPX_SSI = 0;
   localparam logic [7:0] IOPX_MISC2_MASK = 8'h0F;
   localparam logic [7:0] IOPX_PA_TOD = 8'h50; // pins 6 and 4
   localparam logic [7:0] IOPX_PC_MASK = 8'h3F; // six pins
   localparam int IOPX_PC_CLK_PIN = 2;
   // ------------------------------------------------------------
   // sensitivity and divider encodings
   // ------------------------------------------------------------
   localparam logic [1:0] IOPX_SENS_FALL_LOW = 2'h0;
   localparam logic [1:0] IOPX_SENS_RISE = 2'h1;
   localparam logic [1:0] IOPX_SENS_FALL = 2'h2;
   localparam logic [1:0] IOPX_SENS_BOTH = 2'h3;
   localparam logic [1:0] IOPX_DIV2 = 2'h0;
   localparam logic [1:0] IOPX_DIV4 = 2'h2;
   localparam logic [1:0] IOPX_DIV8 = 2'h1;
   localparam logic [1:0] IOPX_DIV16 = 2'h3;
   localparam logic [3:0] IOPX_LIM2 = 4'h0;
   localparam logic [3:0] IOPX_LIM4 = 4'h1;
   localparam logic [3:0] IOPX_LIM8 = 4'h3;
   localparam logic [3:0] IOPX_LIM16 = 4'h7;
   // ------------------------------------------------------------
   // carriers
   // ------------------------------------------------------------
   typedef struct packed {
      logic [7:0] o;  // level driven
      logic [7:0] oe; // enable, high while driving
      logic [7:0] pu; // pull-up on
   } iopx_pins_t;
   typedef struct packed {
      logic ss_int;  // slave select internal control
      logic ss_lvl;  // internal slave select level
      logic mosi_dis;
      logic miso_dis;
   } iopx_spi_t;
endpackage : iopx_pkg

// >>> verif/iopx_pins_model.sv
// pad and wire model for one 8-pin port of the i/o block
// assumes the bench states which pins it drives from outside
`timescale 1ns/100ps
module iopx_pins_model (
   input wire logic clk_i,                 // system clock
   input wire iopx_pkg::iopx_pins_t pad_i, // pad controls from the block
   input wire logic [7:0] ext_en_i,        // outside driver active
   input wire logic [7:0] ext_drv_i,       // outside driver level
   output logic [7:0] pin_o                // resolved wire level
);
   // ------------------------------------------------------------
   // wire resolution
   // ------------------------------------------------------------
   logic [7:0] float_r;
   // undriven pins without pull-up wander, so a missing pull-up shows up
   initial float_r = 8'h55;
   always @(posedge clk_i) float_r <= ~float_r;
   assign pin_o = (pad_i.oe & pad_i.o) | (~pad_i.oe & ext_en_i & ext_drv_i) |
                  (~pad_i.oe & ~ext_en_i & (pad_i.pu | float_r));
endmodule : iopx_pins_model

// >>> verif/iopx_props.sv
// assertion checker for the three-port i/o block, bound to its top
// assumes one clock domain and the byte register port
`timescale 1ns/100ps
module iopx_props (
   input wire logic clk_sys_i,            // system clock
   input wire logic rstn_i,               // async reset, active low
   input wire logic [3:0] addr_i,         // register address
   input wire logic rd_i,                 // read strobe
   input wire logic wr_i,                 // write strobe
   input wire logic [7:0] rdata_o,        // read data
   input wire logic [1:0] vec_fetch_i,    // vector fetch per group
   input wire iopx_pkg::iopx_pins_t pa_o, // port a pads
   input wire iopx_pkg::iopx_pins_t pb_o, // port b pads
   input wire logic cpu_clk_en_o,         // cpu clock enable
   input wire logic [1:0] ext_irq_o       // group requests
);
   // ------------------------------------------------------------
   // properties
   // ------------------------------------------------------------
   default clocking cb @(posedge clk_sys_i);
   endclocking
   default disable iff (!rstn_i);
   logic [4:0] gap_r;
   // one cycle of slack allowed for a divider change
   always_ff @(posedge clk_sys_i or negedge rstn_i) begin
      if (!rstn_i)
         gap_r <= 5'h00;
      else if (cpu_clk_en_o)
         gap_r <= 5'h00;
      else
         gap_r <= gap_r + 5'h01;
   end
   rd_idle_zero_a: assert property (!$past(rd_i) |-> rdata_o == 8'h00)
      else $error("read data not zero outside a read");
   reset_clear_a: assert property ($rose(rstn_i) |-> pa_o == '0 && pb_o == '0 &&
      ext_irq_o == 2'h0) else $error("outputs not cleared by reset");
   tod_sink_only_a: assert property (!(pa_o.oe[6] && pa_o.o[6]) &&
      !(pa_o.oe[4] && pa_o.o[4])) else $error("open drain pin drives high");
   tod_no_pullup_a: assert property (pa_o.pu[6] == 1'b0 && pa_o.pu[4] == 1'b0)
      else $error("pull-up on open drain pin");
   pull_drive_excl_a: assert property (((pa_o.pu & pa_o.oe) | (pb_o.pu & pb_o.oe)) == 8'h00)
      else $error("pull-up on a driven pin");
   clk_en_gap_a: assert property (gap_r <= 5'h10)
      else $error("cpu clock enable gap too long");
   pc_high_zero_a: assert property ($past(rd_i) && $past(addr_i) <= 4'h2 |->
      rdata_o[7:6] == 2'b00) else $error("port c upper bits not zero");
   irq0_drop_cause_a: assert property ($fell(ext_irq_o[0]) |-> $past(vec_fetch_i[0]) ||
      $past(vec_fetch_i[0], 2) || $past(wr_i) || $past(wr_i, 2)) else $error("group0 dropped");
   irq1_drop_cause_a: assert property ($fell(ext_irq_o[1]) |-> $past(vec_fetch_i[1]) ||
      $past(vec_fetch_i[1], 2) || $past(wr_i) || $past(wr_i, 2)) else $error("group1 dropped");
   cover property ($rose(ext_irq_o[0]));
   cover property ($rose(ext_irq_o[1]));
   cover property (rd_i ##1 rdata_o != 8'h00);
endmodule : iopx_props
bind iopx_top iopx_props u_props (.clk_sys_i(clk_sys_i), .rstn_i(rstn_i), .addr_i(addr_i),
   .rd_i(rd_i), .wr_i(wr_i), .rdata_o(rdata_o), .vec_fetch_i(vec_fetch_i), .pa_o(pa_o),
   .pb_o(pb_o), .cpu_clk_en_o(cpu_clk_en_o), .ext_irq_o(ext_irq_o));

// >>> verif/iopx_top_bench.sv
// self-checking bench for the three-port i/o block
// assumes pad models resolve the pins and the bench drives the register port
`timescale 1ns/100ps
module iopx_top_bench;
   logic clk_sys_i, rstn_i, wr_i, rd_i, cpu_clk_en_o, t;
   logic [3:0] addr_i;
   logic [7:0] wdata_i, rdata_o, pb_alt_en_i, pb_alt_o_i, pa_i, pb_i, pc_pin;
   logic [7:0] drva, drvb, drvc, enc, paalt;
   logic [1:0] cpu_irq_mask_i, vec_fetch_i, ext_irq_o, pcg;
   iopx_pkg::iopx_pins_t pa_o, pb_o, pc_o;
   iopx_pkg::iopx_spi_t spi_ctl_o;
   int miscompares, checks_done, n, e;
   logic [1:0] cps [4] = '{iopx_pkg::IOPX_DIV2, iopx_pkg::IOPX_DIV4, iopx_pkg::IOPX_DIV8,
      iopx_pkg::IOPX_DIV16};
   iopx_top i_dut (.clk_sys_i(clk_sys_i), .rstn_i(rstn_i), .addr_i(addr_i), .wdata_i(wdata_i),
      .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .cpu_irq_mask_i(cpu_irq_mask_i),
      .vec_fetch_i(vec_fetch_i), .pa_i(pa_i), .pb_i(pb_i), .pc_i(pc_pin[5:0]),
      .pa_alt_en_i(paalt), .pa_alt_o_i(paalt), .pb_alt_en_i(pb_alt_en_i),
      .pb_alt_o_i(pb_alt_o_i), .pc_alt_en_i(6'h00), .pc_alt_o_i(6'h00),
      .pc_in_group_i(pcg), .pa_o(pa_o), .pb_o(pb_o), .pc_o(pc_o), .spi_ctl_o(spi_ctl_o),
      .cpu_clk_en_o(cpu_clk_en_o), .ext_irq_o(ext_irq_o));
   iopx_pins_model i_pa (.clk_i(clk_sys_i), .pad_i(pa_o), .ext_en_i(8'hFF), .ext_drv_i(drva),
      .pin_o(pa_i));
   iopx_pins_model i_pb (.clk_i(clk_sys_i), .pad_i(pb_o), .ext_en_i(8'hFF), .ext_drv_i(drvb),
      .pin_o(pb_i));
   iopx_pins_model i_pc (.clk_i(clk_sys_i), .pad_i(pc_o), .ext_en_i(enc), .ext_drv_i(drvc),
      .pin_o(pc_pin));
   // ------------------------------------------------------------
   // access tasks
   // ------------------------------------------------------------
   task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
      checks_done++;
      if (seen !== exp) begin
         miscompares++;
         $display("unexpected %s: expected %h seen %h", what, exp, seen);
      end
   endtask : chk
   task automatic cyc(input int k);
      repeat (k) @(posedge clk_sys_i);
      #1;
   endtask : cyc
   task automatic wr(input logic [3:0] a, input logic [7:0] d);
      @(posedge clk_sys_i);
      addr_i <= a;
      wdata_i <= d;
      wr_i <= 1'b1;
      @(posedge clk_sys_i) wr_i <= 1'b0;
   endtask : wr
   task automatic rd(input logic [3:0] a, input logic [7:0] exp, input string what);
      @(posedge clk_sys_i);
      addr_i <= a;
      rd_i <= 1'b1;
      @(posedge clk_sys_i) rd_i <= 1'b0;
      #1 chk(what, rdata_o, exp);
   endtask : rd
   task automatic fetch(input logic [1:0] g);
      @(posedge clk_sys_i) vec_fetch_i <= g;
      @(posedge clk_sys_i) vec_fetch_i <= 2'h0;
   endtask : fetch
   task automatic summarize;
      $display("checks %0d miscompares %0d", checks_done, miscompares);
      if (miscompares == 0 && checks_done > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask : summarize
   // ------------------------------------------------------------
   // sequence
   // ------------------------------------------------------------
   initial begin
      clk_sys_i = 1'b0;
      forever #4 clk_sys_i = ~clk_sys_i;
   end
   initial begin
      #200000;
      miscompares++;
      summarize();
   end
   initial begin
      {rstn_i, wr_i, rd_i, addr_i, wdata_i, pb_alt_en_i, pb_alt_o_i, paalt, pcg} = '0;
      {drva, drvb, drvc, enc, vec_fetch_i, cpu_irq_mask_i} = {32'h0000_00FF, 4'h3};
      repeat (8) @(posedge clk_sys_i);
      rstn_i <= 1'b1;
      cyc(4);
      for (int a = 0; a < 16; a++) rd(a[3:0], 8'h00, "reset value");
      @(posedge clk_sys_i) drva <= 8'h3C;
      wr(iopx_pkg::IOPX_PA_DATA, 8'h5A);
      rd(iopx_pkg::IOPX_PA_DATA, 8'h3C, "pa input read");
      wr(iopx_pkg::IOPX_PA_DIR, 8'h0F);
      rd(iopx_pkg::IOPX_PA_DATA, 8'h3A, "pa mixed read");
      wr(iopx_pkg::IOPX_PA_OPT, 8'hFF);
      cyc(2);
      chk("pa pull-up", pa_o.pu, 8'hA0);
      chk("pa push-pull", pa_o.oe, 8'h0F);
      wr(iopx_pkg::IOPX_PA_DIR, 8'hFF);
      cyc(2);
      chk("pa true od", pa_o.oe, 8'hAF);
      wr(iopx_pkg::IOPX_PA_OPT, 8'h00);
      cyc(2);
      chk("pa open drain", pa_o.oe, 8'hA5);
      rd(iopx_pkg::IOPX_PA_DATA, 8'h5A, "pa output read");
      wr(iopx_pkg::IOPX_PA_DIR, 8'h00);
      wr(iopx_pkg::IOPX_PA_OPT, 8'h01);
      wr(iopx_pkg::IOPX_PC_OPT, 8'h3F);
      @(posedge clk_sys_i) drva <= 8'hFF;
      @(posedge clk_sys_i) enc <= 8'h00;
      cyc(4);
      rd(iopx_pkg::IOPX_PC_DATA, 8'h3F, "pc pull-up read");
      for (int m = 0; m < 4; m++) begin
         wr(iopx_pkg::IOPX_MISC1, {3'h0, m[1:0], 3'h0});
         cyc(6);
         fetch(2'b01);
         @(posedge clk_sys_i) drva <= 8'hFE;
         cyc(6);
         chk("irq fall", {7'h0, ext_irq_o[0]}, {7'h0, m != 1});
         fetch(2'b01);
         cyc(6);
         chk("irq low level", {7'h0, ext_irq_o[0]}, {7'h0, m == 0});
         @(posedge clk_sys_i) drva <= 8'hFF;
         cyc(6);
         chk("irq rise", {7'h0, ext_irq_o[0]}, {7'h0, m != 2});
         fetch(2'b01);
         cyc(3);
         chk("irq fetch clear", {7'h0, ext_irq_o[0]}, 8'h00);
      end
      @(posedge clk_sys_i) cpu_irq_mask_i <= 2'b01;
      wr(iopx_pkg::IOPX_MISC1, 8'hE0);
      rd(iopx_pkg::IOPX_MISC1, 8'h38, "misc1 locked");
      chk("clock out oe", pc_o.oe & 8'h04, 8'h04);
      t = pc_o.o[2];
      cyc(1);
      chk("clock out toggle", {7'h0, pc_o.o[2]}, {7'h0, ~t});
      @(posedge clk_sys_i) cpu_irq_mask_i <= 2'b11;
      wr(iopx_pkg::IOPX_MISC1, 8'h98);
      wr(iopx_pkg::IOPX_PB_OPT, 8'hC0);
      @(posedge clk_sys_i) drvb <= 8'hBF;
      cyc(6);
      fetch(2'b10);
      @(posedge clk_sys_i) drvb <= 8'h3F;
      cyc(6);
      chk("irq combined", {7'h0, ext_irq_o[1]}, 8'h00);
      @(posedge clk_sys_i) drvb <= 8'hFF;
      cyc(6);
      @(posedge clk_sys_i) drvb <= 8'h7F;
      cyc(6);
      chk("group1 fall", {7'h0, ext_irq_o[1]}, 8'h01);
      wr(iopx_pkg::IOPX_MISC1, 8'hD8);
      cyc(1);
      chk("sens change clear", {7'h0, ext_irq_o[1]}, 8'h00);
      for (int k = 0; k < 5; k++) begin
         wr(iopx_pkg::IOPX_MISC1, (k < 4) ? (8'hD9 | {5'h0, cps[k], 1'b0}) : 8'hD8);
         cyc(20);
         n = 0;
         e = (k < 4) ? (64 >> (k + 1)) : 64;
         repeat (64) begin
            cyc(1);
            n += cpu_clk_en_o;
         end
         chk("cpu clock rate", n[7:0], e[7:0]);
      end
      @(posedge clk_sys_i) pb_alt_en_i <= 8'h08;
      @(posedge clk_sys_i) pb_alt_o_i <= 8'h08;
      cyc(3);
      chk("alt override", pb_o.oe & pb_o.o & 8'h08, 8'h08);
      wr(iopx_pkg::IOPX_MISC2, 8'hF9);
      rd(iopx_pkg::IOPX_MISC2, 8'h09, "misc2 read");
      chk("spi controls", {4'h0, spi_ctl_o}, 8'h06);
      // peripheral drives high on pin 0 and on true open drain pin 6
      @(posedge clk_sys_i) paalt <= 8'h41;
      cyc(3);
      chk("od alt override", pa_o.oe & 8'h41, 8'h01);
      @(posedge clk_sys_i) pcg <= 2'b01;
      @(posedge clk_sys_i) enc <= 8'h01;
      cyc(6);
      chk("port c in group0", {7'h0, ext_irq_o[0]}, 8'h01);
      chk("port c out of group1", {7'h0, ext_irq_o[1]}, 8'h00);
      summarize();
   end
endmodule : iopx_top_bench
